// ===== pkg/spr_pkg.sv
// Constants for the shared pin function routing block
package spr_pkg;

   // Pad indices
   localparam int NUM_PADS = 6;
   localparam int PAD_A0 = 0;
   localparam int PAD_A1 = 1;
   localparam int PAD_A2 = 2;
   localparam int PAD_A7 = 3;
   localparam int PAD_B3 = 4;
   localparam int PAD_B4 = 5;

   // Pad configuration field layout
   localparam int CFG_W = 4;
   localparam int CFG_A0_LSB = 0;
   localparam int CFG_A1_LSB = 4;
   localparam int CFG_A2_LSB = 8;
   localparam int CFG_A7_LSB = 12;
   localparam int CFG_B3_LSB = 12;
   localparam int CFG_B4_LSB = 0;

   // Pad configuration codes
   localparam logic [3:0] CFG_ANALOG = 4'h0;
   localparam logic [3:0] CFG_OUT = 4'h1;
   localparam logic [3:0] CFG_INPUT = 4'h4;
   localparam logic [3:0] CFG_OUT_OD = 4'h5;
   localparam logic [3:0] CFG_ALT_OUT = 4'h9;
   localparam logic [3:0] CFG_ALT_OD = 4'hD;

   // Control bit positions
   localparam int DBG_REGEN_OFF_BIT = 4;
   localparam int REMAP_T2C1_BIT = 4;
   localparam int REMAP_T2C3_BIT = 6;
   localparam int REMAP_T2C4_BIT = 7;
   localparam int UART_HANDSHAKE_BIT = 5;
   localparam int SPI_MASTER_BIT = 4;

   // Serial controller modes
   typedef enum logic [1:0] {
      SPR_MODE_OFF,
      SPR_MODE_UART,
      SPR_MODE_SPI,
      SPR_MODE_TWI
   } spr_mode_t;

endpackage

// ===== design/spr_sync.sv
// Two-stage synchroniser for pad inputs
`timescale 1ns/1ns
`default_nettype none
module spr_sync
   import spr_pkg::*;
#(
   parameter int W = NUM_PADS
) (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);

   typedef struct packed {
      logic [W-1:0] stage1;
      logic [W-1:0] stage2;
   } spr_sync_st_t;

   spr_sync_st_t st_r;
   spr_sync_st_t st_nxt;

   // First stage feeds only the second
   always_comb begin
      st_nxt.stage1 = async_in;
      st_nxt.stage2 = st_r.stage1;
   end

   // State register
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign sync_out = st_r.stage2;

endmodule
`default_nettype wire

// ===== design/spr_pin_router.sv
// Pin function routing for six shared digital pads
`timescale 1ns/1ns
`default_nettype none
module spr_pin_router
   import spr_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset,
   // Pads
   input wire logic [NUM_PADS-1:0] pad_in,
   output logic [NUM_PADS-1:0] pad_out,
   output logic [NUM_PADS-1:0] pad_oe,
   // Configuration
   input wire logic [15:0] port_a_lower_pad_config,
   input wire logic [15:0] port_a_upper_pad_config,
   input wire logic [15:0] port_b_lower_pad_config,
   input wire logic [15:0] port_b_upper_pad_config,
   input wire logic [7:0] debug_pad_config,
   input wire logic [7:0] timer2_remap_reg,
   input wire logic [7:0] ser1_uart_config,
   input wire logic [7:0] ser1_spi_config,
   input wire logic [7:0] ser2_spi_config,
   input wire logic [1:0] ser1_mode_select,
   input wire logic [1:0] ser2_mode_select,
   // General-purpose I/O
   input wire logic [NUM_PADS-1:0] gpio_data_out,
   output logic [NUM_PADS-1:0] gpio_data_in,
   // Regulator enable request
   input wire logic ext_regulator_off,
   // Timers
   input wire logic timer1_channel4_out,
   input wire logic timer1_channel4_oe,
   input wire logic timer2_channel1_out,
   input wire logic timer2_channel1_oe,
   input wire logic timer2_channel3_out,
   input wire logic timer2_channel3_oe,
   input wire logic timer2_channel4_out,
   input wire logic timer2_channel4_oe,
   output logic timer1_channel4_in,
   output logic timer2_channel1_in,
   output logic timer2_channel3_in,
   output logic timer2_channel4_in,
   // Serial controller 1
   input wire logic ser1_request_to_send_n,
   input wire logic ser1_spi_clock_out,
   output logic ser1_clear_to_send_n,
   output logic ser1_spi_clock_in,
   output logic ser1_slave_select_n,
   // Serial controller 2
   input wire logic ser2_master_data_out,
   input wire logic ser2_slave_data_out,
   input wire logic ser2_two_wire_data_out,
   output logic ser2_master_data_in,
   output logic ser2_slave_data_in,
   output logic ser2_two_wire_data_in
);

   typedef struct packed {
      logic [NUM_PADS-1:0] pad_out;
      logic [NUM_PADS-1:0] pad_oe;
      logic [NUM_PADS-1:0] gpio_in;
      logic t1c4_in;
      logic t2c1_in;
      logic t2c3_in;
      logic t2c4_in;
      logic cts_n;
      logic sclk_in;
      logic ssel_n;
      logic s2_mosi_in;
      logic s2_miso_in;
      logic s2_sda_in;
   } spr_state_t;

   // Slave select and two-wire data idle high after reset; clear-to-send reads low (asserted)
   localparam spr_state_t ST_RESET = '{
      pad_out: '0, pad_oe: '0, gpio_in: '0,
      t1c4_in: 1'h0, t2c1_in: 1'h0, t2c3_in: 1'h0, t2c4_in: 1'h0,
      cts_n: 1'h0, sclk_in: 1'h0, ssel_n: 1'h1,
      s2_mosi_in: 1'h0, s2_miso_in: 1'h0, s2_sda_in: 1'h1};

   spr_state_t st_r;
   spr_state_t st_nxt;
   logic [NUM_PADS-1:0] pad_sync;

   // Pad inputs cross into clk_sys
   spr_sync #(
      .W(NUM_PADS)
   ) u_sync (
      .clk_sys(clk_sys),
      .reset(reset),
      .async_in(pad_in),
      .sync_out(pad_sync)
   );

   // Push-pull or open-drain drive, returns {oe, out}
   function automatic logic [1:0] drive(input logic od, input logic v);
      logic [1:0] r;
      r = od ? {~v, 1'h0} : {1'h1, v};
      return r;
   endfunction

   // General-purpose pad behaviour, returns {oe, out}
   function automatic logic [1:0] gpio_pin(input logic [3:0] cfg,
                                           input logic d);
      logic [1:0] r;
      case (cfg)
         CFG_OUT: r = drive(1'h0, d);
         CFG_OUT_OD: r = drive(1'h1, d);
         default: r = 2'h0;
      endcase
      return r;
   endfunction

   logic [3:0] cfg_a0;
   logic [3:0] cfg_a1;
   logic [3:0] cfg_a2;
   logic [3:0] cfg_a7;
   logic [3:0] cfg_b3;
   logic [3:0] cfg_b4;
   logic remap1;
   logic remap3;
   logic remap4;
   spr_mode_t mode1;
   spr_mode_t mode2;
   logic s1_master;
   logic s2_master;
   logic s1_handshake;

   // Field extraction
   assign cfg_a0 = port_a_lower_pad_config[CFG_A0_LSB +: CFG_W];
   assign cfg_a1 = port_a_lower_pad_config[CFG_A1_LSB +: CFG_W];
   assign cfg_a2 = port_a_lower_pad_config[CFG_A2_LSB +: CFG_W];
   assign cfg_a7 = port_a_upper_pad_config[CFG_A7_LSB +: CFG_W];
   assign cfg_b3 = port_b_lower_pad_config[CFG_B3_LSB +: CFG_W];
   assign cfg_b4 = port_b_upper_pad_config[CFG_B4_LSB +: CFG_W];
   assign remap1 = timer2_remap_reg[REMAP_T2C1_BIT];
   assign remap3 = timer2_remap_reg[REMAP_T2C3_BIT];
   assign remap4 = timer2_remap_reg[REMAP_T2C4_BIT];
   assign mode1 = spr_mode_t'(ser1_mode_select);
   assign mode2 = spr_mode_t'(ser2_mode_select);
   assign s1_master = ser1_spi_config[SPI_MASTER_BIT];
   assign s2_master = ser2_spi_config[SPI_MASTER_BIT];
   assign s1_handshake = ser1_uart_config[UART_HANDSHAKE_BIT];

   // Routing of all pads and peripheral inputs
   always_comb begin
      st_nxt = st_r;
      st_nxt.gpio_in = pad_sync;

      // Port A bit 7
      // regulator enable by default
      if (!debug_pad_config[DBG_REGEN_OFF_BIT]) begin
         {st_nxt.pad_oe[PAD_A7], st_nxt.pad_out[PAD_A7]} =
            drive(1'h1, ~ext_regulator_off);
      end else if (cfg_a7 == CFG_ALT_OUT && timer1_channel4_oe) begin
         {st_nxt.pad_oe[PAD_A7], st_nxt.pad_out[PAD_A7]} =
            drive(1'h0, timer1_channel4_out);
      end else begin
         {st_nxt.pad_oe[PAD_A7], st_nxt.pad_out[PAD_A7]} =
            gpio_pin(cfg_a7, gpio_data_out[PAD_A7]);
      end

      // Port B bit 3
      // timer 2 channel 3 remapped here
      if (cfg_b3 == CFG_ALT_OUT && timer2_channel3_oe && remap3) begin
         {st_nxt.pad_oe[PAD_B3], st_nxt.pad_out[PAD_B3]} =
            drive(1'h0, timer2_channel3_out);
      end else if (cfg_b3 == CFG_ALT_OUT && mode1 == SPR_MODE_SPI &&
                   s1_master) begin
         {st_nxt.pad_oe[PAD_B3], st_nxt.pad_out[PAD_B3]} =
            drive(1'h0, ser1_spi_clock_out);
      end else begin
         {st_nxt.pad_oe[PAD_B3], st_nxt.pad_out[PAD_B3]} =
            gpio_pin(cfg_b3, gpio_data_out[PAD_B3]);
      end

      // Port B bit 4
      // timer 2 channel 4 remapped here
      if (cfg_b4 == CFG_ALT_OUT && timer2_channel4_oe && remap4) begin
         {st_nxt.pad_oe[PAD_B4], st_nxt.pad_out[PAD_B4]} =
            drive(1'h0, timer2_channel4_out);
      end else if (cfg_b4 == CFG_ALT_OUT && mode1 == SPR_MODE_UART &&
                   s1_handshake) begin
         {st_nxt.pad_oe[PAD_B4], st_nxt.pad_out[PAD_B4]} =
            drive(1'h0, ser1_request_to_send_n);
      end else begin
         {st_nxt.pad_oe[PAD_B4], st_nxt.pad_out[PAD_B4]} =
            gpio_pin(cfg_b4, gpio_data_out[PAD_B4]);
      end

      // Port A bit 0
      // timer 2 channel 1 unless remapped
      if (cfg_a0 == CFG_ALT_OUT && timer2_channel1_oe && !remap1) begin
         {st_nxt.pad_oe[PAD_A0], st_nxt.pad_out[PAD_A0]} =
            drive(1'h0, timer2_channel1_out);
      // serial 2 master data out, timer wins
      end else if (cfg_a0 == CFG_ALT_OUT && mode2 == SPR_MODE_SPI &&
                   s2_master) begin
         {st_nxt.pad_oe[PAD_A0], st_nxt.pad_out[PAD_A0]} =
            drive(1'h0, ser2_master_data_out);
      end else begin
         {st_nxt.pad_oe[PAD_A0], st_nxt.pad_out[PAD_A0]} =
            gpio_pin(cfg_a0, gpio_data_out[PAD_A0]);
      end

      // Port A bit 1
      // timer 2 channel 3 unless remapped
      if (cfg_a1 == CFG_ALT_OUT && timer2_channel3_oe && !remap3) begin
         {st_nxt.pad_oe[PAD_A1], st_nxt.pad_out[PAD_A1]} =
            drive(1'h0, timer2_channel3_out);
      // serial 2 slave data out, timer wins
      end else if (cfg_a1 == CFG_ALT_OUT && mode2 == SPR_MODE_SPI &&
                   !s2_master) begin
         {st_nxt.pad_oe[PAD_A1], st_nxt.pad_out[PAD_A1]} =
            drive(1'h0, ser2_slave_data_out);
      end else if (cfg_a1 == CFG_ALT_OD && mode2 == SPR_MODE_TWI &&
                   !(timer2_channel3_oe && !remap3)) begin
         {st_nxt.pad_oe[PAD_A1], st_nxt.pad_out[PAD_A1]} =
            drive(1'h1, ser2_two_wire_data_out);
      end else begin
         {st_nxt.pad_oe[PAD_A1], st_nxt.pad_out[PAD_A1]} =
            gpio_pin(cfg_a1, gpio_data_out[PAD_A1]);
      end

      // Port A bit 2
      // timer 2 channel 4 unless remapped
      if (cfg_a2 == CFG_ALT_OUT && timer2_channel4_oe && !remap4) begin
         {st_nxt.pad_oe[PAD_A2], st_nxt.pad_out[PAD_A2]} =
            drive(1'h0, timer2_channel4_out);
      end else begin
         {st_nxt.pad_oe[PAD_A2], st_nxt.pad_out[PAD_A2]} =
            gpio_pin(cfg_a2, gpio_data_out[PAD_A2]);
      end

      // Timer capture inputs
      // fixed source for timer 1 channel 4
      st_nxt.t1c4_in = pad_sync[PAD_A7];
      // channel 1 only from port A bit 0
      st_nxt.t2c1_in = remap1 ? 1'h0 : pad_sync[PAD_A0];
      st_nxt.t2c3_in = remap3 ? pad_sync[PAD_B3] : pad_sync[PAD_A1];
      st_nxt.t2c4_in = remap4 ? pad_sync[PAD_B4] : pad_sync[PAD_A2];

      // Serial 1 inputs
      // clear-to-send when handshake on
      st_nxt.cts_n = (mode1 == SPR_MODE_UART && s1_handshake) ?
                     pad_sync[PAD_B3] : 1'h0;
      st_nxt.sclk_in = (mode1 == SPR_MODE_SPI && !s1_master) ?
                       pad_sync[PAD_B3] : 1'h0;
      st_nxt.ssel_n = (mode1 == SPR_MODE_SPI && !s1_master) ?
                      pad_sync[PAD_B4] : 1'h1;

      // Serial 2 inputs
      // slave receives data on port A bit 0
      st_nxt.s2_mosi_in = (mode2 == SPR_MODE_SPI && !s2_master) ?
                          pad_sync[PAD_A0] : 1'h0;
      // master reads data on port A bit 1
      st_nxt.s2_miso_in = (mode2 == SPR_MODE_SPI && s2_master) ?
                          pad_sync[PAD_A1] : 1'h0;
      st_nxt.s2_sda_in = (mode2 == SPR_MODE_TWI) ?
                         pad_sync[PAD_A1] : 1'h1;
   end

   // State register
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         st_r <= ST_RESET;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Registered outputs
   assign pad_out = st_r.pad_out;
   assign pad_oe = st_r.pad_oe;
   assign gpio_data_in = st_r.gpio_in;
   assign timer1_channel4_in = st_r.t1c4_in;
   assign timer2_channel1_in = st_r.t2c1_in;
   assign timer2_channel3_in = st_r.t2c3_in;
   assign timer2_channel4_in = st_r.t2c4_in;
   assign ser1_clear_to_send_n = st_r.cts_n;
   assign ser1_spi_clock_in = st_r.sclk_in;
   assign ser1_slave_select_n = st_r.ssel_n;
   assign ser2_master_data_in = st_r.s2_mosi_in;
   assign ser2_slave_data_in = st_r.s2_miso_in;
   assign ser2_two_wire_data_in = st_r.s2_sda_in;

endmodule
`default_nettype wire

// ===== test/spr_checker.sv
// Port-level assertions for the pin router
`timescale 1ns/1ns
`default_nettype none
module spr_checker
   import spr_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic [NUM_PADS-1:0] pad_in,
   input wire logic [NUM_PADS-1:0] pad_out,
   input wire logic [NUM_PADS-1:0] pad_oe,
   input wire logic [15:0] port_a_lower_pad_config,
   input wire logic [15:0] port_a_upper_pad_config,
   input wire logic [15:0] port_b_lower_pad_config,
   input wire logic [15:0] port_b_upper_pad_config,
   input wire logic [7:0] debug_pad_config,
   input wire logic [7:0] timer2_remap_reg,
   input wire logic [7:0] ser1_uart_config,
   input wire logic [7:0] ser1_spi_config,
   input wire logic [1:0] ser1_mode_select,
   input wire logic [1:0] ser2_mode_select,
   input wire logic ext_regulator_off,
   input wire logic timer1_channel4_out,
   input wire logic timer1_channel4_oe,
   input wire logic timer2_channel3_out,
   input wire logic timer2_channel3_oe,
   input wire logic timer2_channel4_out,
   input wire logic timer2_channel4_oe,
   input wire logic ser1_request_to_send_n,
   input wire logic ser1_spi_clock_out,
   input wire logic ser2_two_wire_data_out,
   input wire logic timer1_channel4_in,
   input wire logic timer2_channel3_in
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);
   logic [1:0] up_r;
   // Cycles since reset, so the input pipeline is full
   always_ff @(posedge clk_sys) begin
      if (reset) up_r <= 2'h0;
      else if (up_r != 2'h3) up_r <= up_r + 2'h1;
   end
   chk_regulator_pull: assert property (
      !debug_pad_config[4] |=>
      !pad_out[3] && pad_oe[3] == $past(ext_regulator_off))
      else $error("regulator pad wrong");
   chk_timer1_drive: assert property (
      debug_pad_config[4] && timer1_channel4_oe &&
      port_a_upper_pad_config[15:12] == 4'h9 |=>
      pad_oe[3] && pad_out[3] == $past(timer1_channel4_out))
      else $error("timer 1 pad output wrong");
   chk_timer1_capture: assert property (
      up_r == 2'h3 |-> timer1_channel4_in == $past(pad_in[3], 3))
      else $error("timer 1 capture wrong");
   chk_timer2_ch3_pick: assert property (
      up_r == 2'h3 |-> timer2_channel3_in == ($past(timer2_remap_reg[6]) ?
      $past(pad_in[4], 3) : $past(pad_in[1], 3)))
      else $error("timer 2 channel 3 capture wrong");
   chk_timer2_ch4_drive: assert property (
      timer2_remap_reg[7] && timer2_channel4_oe &&
      port_b_upper_pad_config[3:0] == 4'h9 |=>
      pad_oe[5] && pad_out[5] == $past(timer2_channel4_out))
      else $error("timer 2 channel 4 pad wrong");
   chk_rts_drive: assert property (
      ser1_mode_select == 2'h1 && ser1_uart_config[5] &&
      port_b_upper_pad_config[3:0] == 4'h9 &&
      !(timer2_channel4_oe && timer2_remap_reg[7]) |=>
      pad_oe[5] && pad_out[5] == $past(ser1_request_to_send_n))
      else $error("request to send pad wrong");
   chk_sclk_or_timer: assert property (
      ser1_mode_select == 2'h2 && ser1_spi_config[4] &&
      port_b_lower_pad_config[15:12] == 4'h9 |=> pad_oe[4] &&
      pad_out[4] == ($past(timer2_channel3_oe) && $past(timer2_remap_reg[6])
      ? $past(timer2_channel3_out) : $past(ser1_spi_clock_out)))
      else $error("serial clock pad wrong");
   chk_two_wire_od: assert property (
      ser2_mode_select == 2'h3 && port_a_lower_pad_config[7:4] == 4'hD &&
      !(timer2_channel3_oe && !timer2_remap_reg[6]) |=>
      !pad_out[1] && pad_oe[1] == !$past(ser2_two_wire_data_out))
      else $error("two-wire data pad wrong");
endmodule
`default_nettype wire

// ===== test/spr_board.sv
// Board devices and pull-ups on the shared pads
`timescale 1ns/1ns
`default_nettype none
module spr_board
   import spr_pkg::*;
(
   input wire logic [NUM_PADS-1:0] pad_out,
   input wire logic [NUM_PADS-1:0] pad_oe,
   input wire logic [NUM_PADS-1:0] dev_en,
   input wire logic [NUM_PADS-1:0] dev_val,
   output logic [NUM_PADS-1:0] pad_in,
   output logic regulator_on
);
   // Chip drive, else device drive, else pull-up; a clash gives X
   always_comb begin
      for (int i = 0; i < NUM_PADS; i++) begin
         if (pad_oe[i]) pad_in[i] = dev_en[i] ? 1'hX : pad_out[i];
         else pad_in[i] = dev_en[i] ? dev_val[i] : 1'h1;
      end
   end
   // Regulator runs while its open-drain enable floats high
   assign regulator_on = pad_in[3];
endmodule
`default_nettype wire

// ===== test/tb.sv
// Self-checking bench for the pin router
`timescale 1ns/1ns
`default_nettype none
module tb;
   logic clk_sys = 1'h0, reset = 1'h1, ext_regulator_off = 1'h0, regulator_on;
   logic [5:0] pad_in, pad_out, pad_oe, gpio_data_in, gpio_data_out = 6'h00;
   logic [5:0] dev_en = 6'h00, dev_val = 6'h00;
   logic [15:0] port_a_lower_pad_config = 16'h0000;
   logic [15:0] port_a_upper_pad_config = 16'h0000;
   logic [15:0] port_b_lower_pad_config = 16'h0000;
   logic [15:0] port_b_upper_pad_config = 16'h0000;
   logic [7:0] debug_pad_config = 8'h00, timer2_remap_reg = 8'h00;
   logic [7:0] ser1_uart_config = 8'h00, ser1_spi_config = 8'h00;
   logic [7:0] ser2_spi_config = 8'h00;
   logic [1:0] ser1_mode_select = 2'h0, ser2_mode_select = 2'h0;
   logic timer1_channel4_out = 1'h0, timer1_channel4_oe = 1'h0;
   logic timer2_channel1_out = 1'h0, timer2_channel1_oe = 1'h0;
   logic timer2_channel3_out = 1'h0, timer2_channel3_oe = 1'h0;
   logic timer2_channel4_out = 1'h0, timer2_channel4_oe = 1'h0;
   logic ser1_request_to_send_n = 1'h1, ser1_spi_clock_out = 1'h0;
   logic ser2_master_data_out = 1'h0, ser2_slave_data_out = 1'h0;
   logic ser2_two_wire_data_out = 1'h1;
   logic timer1_channel4_in, timer2_channel1_in, timer2_channel3_in;
   logic timer2_channel4_in, ser1_clear_to_send_n, ser1_spi_clock_in;
   logic ser1_slave_select_n, ser2_master_data_in, ser2_slave_data_in;
   logic ser2_two_wire_data_in;
   int errors = 0;
   int check_count = 0;
   spr_pin_router dut (.*);
   spr_board board (.pad_out, .pad_oe, .dev_en, .dev_val, .pad_in,
      .regulator_on);
   // 25 MHz system clock
   initial begin
      forever #20 clk_sys = ~clk_sys;
   end
   // Compare and count
   task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
      check_count++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Let n edges pass, then settle
   task automatic go(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   // Regulator enable, then timer 1 after hand-over
   task automatic s_regulator();
      chk({pad_oe[3], regulator_on}, 2'h1);
      @(posedge clk_sys);
      port_a_upper_pad_config <= 16'h9000;
      timer1_channel4_oe <= 1'h1;
      timer1_channel4_out <= 1'h1;
      ext_regulator_off <= 1'h1;
      go(2);
      chk({pad_oe[3], pad_out[3], regulator_on}, 3'h4);
      @(posedge clk_sys);
      debug_pad_config <= 8'h10;
      go(2);
      chk({pad_oe[3], pad_out[3]}, 2'h3);
      @(posedge clk_sys);
      timer1_channel4_out <= 1'h0;
      go(2);
      chk({pad_oe[3], pad_out[3]}, 2'h2);
      @(posedge clk_sys);
      timer1_channel4_oe <= 1'h0;
      go(2);
      chk(pad_oe[3], 1'h0);
   endtask
   // Capture inputs with and without remap
   task automatic s_capture();
      logic [5:0] v;
      for (int k = 0; k < 4; k++) begin
         v = k[0] ? 6'h23 : 6'h1C;
         @(posedge clk_sys);
         dev_en <= 6'h3F;
         dev_val <= v;
         timer2_remap_reg <= k[1] ? 8'hD0 : 8'h00;
         go(4);
         chk(gpio_data_in, v);
         chk(timer1_channel4_in, v[3]);
         chk(timer2_channel3_in, k[1] ? v[4] : v[1]);
         chk(timer2_channel4_in, k[1] ? v[5] : v[2]);
         chk(timer2_channel1_in, k[1] ? 1'h0 : v[0]);
      end
   endtask
   // Timer outputs follow remap and win over the serial output
   task automatic s_timer_out();
      @(posedge clk_sys);
      dev_en <= 6'h00;
      port_a_lower_pad_config <= 16'h0999;
      port_b_lower_pad_config <= 16'h9000;
      port_b_upper_pad_config <= 16'h0009;
      timer2_channel1_oe <= 1'h1;
      timer2_channel3_oe <= 1'h1;
      timer2_channel4_oe <= 1'h1;
      timer2_channel1_out <= 1'h1;
      timer2_channel4_out <= 1'h1;
      ser1_mode_select <= 2'h1;
      ser1_uart_config <= 8'h20;
      ser1_request_to_send_n <= 1'h0;
      timer2_remap_reg <= 8'h00;
      go(2);
      chk({pad_oe, pad_out & 6'h27}, {6'h27, 6'h05});
      @(posedge clk_sys);
      timer2_remap_reg <= 8'hD0;
      go(2);
      chk({pad_oe, pad_out & 6'h30}, {6'h30, 6'h20});
      @(posedge clk_sys);
      timer2_channel4_oe <= 1'h0;
      go(2);
      chk({pad_oe, pad_out & 6'h30}, {6'h30, 6'h00});
   endtask
   // Serial 1 handshakes and SPI pins
   task automatic s_serial1();
      @(posedge clk_sys);
      timer2_channel3_oe <= 1'h0;
      timer2_channel1_oe <= 1'h0;
      timer2_remap_reg <= 8'h00;
      dev_en <= 6'h10;
      dev_val <= 6'h10;
      go(4);
      chk({ser1_clear_to_send_n, pad_oe[5], pad_out[5]}, 3'h6);
      @(posedge clk_sys);
      ser1_uart_config <= 8'h00;
      go(2);
      chk({ser1_clear_to_send_n, pad_oe[5]}, 2'h0);
      @(posedge clk_sys);
      ser1_mode_select <= 2'h2;
      ser1_spi_config <= 8'h10;
      ser1_spi_clock_out <= 1'h1;
      dev_en <= 6'h00;
      go(2);
      chk({pad_oe[4], pad_out[4]}, 2'h3);
      @(posedge clk_sys);
      timer2_channel3_oe <= 1'h1;
      timer2_remap_reg <= 8'h40;
      go(2);
      chk({pad_oe[4], pad_out[4]}, 2'h2);
      @(posedge clk_sys);
      timer2_channel3_oe <= 1'h0;
      timer2_remap_reg <= 8'h00;
      ser1_spi_config <= 8'h00;
      dev_en <= 6'h30;
      go(4);
      chk({pad_oe[4], ser1_spi_clock_in, ser1_slave_select_n}, 3'h2);
   endtask
   // Serial 2 SPI both roles, two-wire data, plain GPIO drive
   task automatic s_serial2();
      @(posedge clk_sys);
      ser1_mode_select <= 2'h0;
      dev_en <= 6'h02;
      dev_val <= 6'h02;
      ser2_mode_select <= 2'h2;
      ser2_spi_config <= 8'h10;
      ser2_master_data_out <= 1'h1;
      go(4);
      chk({pad_oe[1:0], pad_out[0], ser2_slave_data_in}, 4'h7);
      @(posedge clk_sys);
      ser2_spi_config <= 8'h00;
      ser2_slave_data_out <= 1'h1;
      dev_en <= 6'h01;
      dev_val <= 6'h01;
      go(4);
      chk({pad_oe[1], pad_out[1], pad_oe[0], ser2_master_data_in}, 4'hD);
      @(posedge clk_sys);
      ser2_mode_select <= 2'h3;
      port_a_lower_pad_config <= 16'h01D9;
      gpio_data_out <= 6'h04;
      ser2_two_wire_data_out <= 1'h0;
      dev_en <= 6'h00;
      go(2);
      chk({pad_oe[2:1], pad_out[2:1]}, 4'hE);
      @(posedge clk_sys);
      ser2_two_wire_data_out <= 1'h1;
      go(4);
      chk({pad_oe[1], ser2_two_wire_data_in}, 2'h1);
      @(posedge clk_sys);
      dev_en <= 6'h02;
      dev_val <= 6'h00;
      go(4);
      chk(ser2_two_wire_data_in, 1'h0);
      // Open-drain GPIO code on port A bit 2
      @(posedge clk_sys);
      port_a_lower_pad_config <= 16'h05D9;
      gpio_data_out <= 6'h00;
      go(2);
      chk({pad_oe[2], pad_out[2]}, 2'h2);
      @(posedge clk_sys);
      gpio_data_out <= 6'h04;
      go(4);
      chk({pad_oe[2], pad_out[2], gpio_data_in[2]}, 3'h1);
   endtask
   // Counts and verdict
   task automatic report_and_stop();
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // Hang guard
   initial begin
      repeat (5000) @(posedge clk_sys);
      errors++;
      report_and_stop();
   end
   // Main sequence
   initial begin
      repeat (10) @(posedge clk_sys);
      reset <= 1'h0;
      go(3);
      s_regulator();
      s_capture();
      s_timer_out();
      s_serial1();
      s_serial2();
      report_and_stop();
   end
endmodule
bind spr_pin_router spr_checker chk_i (.*);
`default_nettype wire
